// *** hdl/sxa_cfg.svh ***
// offsets, field positions, reset values and codes for the shift/xy datapath
`ifndef SXA_CFG_SVH
`define SXA_CFG_SVH

// register byte offsets on the apb slave
`define SXA_OFF_DST      8'h00
`define SXA_OFF_SRC      8'h04
`define SXA_OFF_FLAGS    8'h08
`define SXA_OFF_CMD      8'h0C
`define SXA_OFF_COND     8'h10

// command word layout
`define SXA_CMD_OP_LSB   0
`define SXA_CMD_OP_W     4
`define SXA_CMD_REGCNT   4
`define SXA_CMD_K_LSB    5
`define SXA_CMD_K_W      5
`define SXA_CMD_CC_LSB   10
`define SXA_CMD_CC_W     4
`define SXA_CMD_W        14

// reset values
`define SXA_RST_DST      32'h0000_0000
`define SXA_RST_SRC      32'h0000_0000
`define SXA_RST_FLAGS    4'h0
`define SXA_RST_CMD      14'h0000

// most negative operand, the one value magnitude cannot represent
`define SXA_MOST_NEG     32'h8000_0000

// jump condition codes
`define SXA_CC_UC        4'h0
`define SXA_CC_P         4'h1
`define SXA_CC_LS        4'h2
`define SXA_CC_HI        4'h3
`define SXA_CC_LT        4'h4
`define SXA_CC_GE        4'h5
`define SXA_CC_LE        4'h6
`define SXA_CC_GT        4'h7
`define SXA_CC_B         4'h8
`define SXA_CC_NB        4'h9
`define SXA_CC_EQ        4'hA
`define SXA_CC_NE        4'hB
`define SXA_CC_V         4'hC
`define SXA_CC_NV        4'hD
`define SXA_CC_N         4'hE
`define SXA_CC_NN        4'hF

`endif

// *** hdl/sxa_pkg.sv ***
// types shared by the shift/xy datapath modules
package sxa_pkg;

  // operations selected by the command word
  typedef enum logic [3:0] {
    op_nop,
    op_rotate_left,
    op_arith_shift_up,
    op_logical_shift_up,
    op_arith_shift_down,
    op_logical_shift_down,
    op_magnitude,
    op_copy_low_half,
    op_copy_high_half,
    op_add_halves,
    op_sub_halves,
    op_compare_halves
  } sxa_op_t;

  // barrel shifter modes
  typedef enum logic [2:0] {
    sh_rotl,
    sh_sla,
    sh_sll,
    sh_sra,
    sh_srl
  } sxa_shift_t;

  // xy half-wise arithmetic modes
  typedef enum logic {
    xy_add,
    xy_sub
  } sxa_xy_t;

  // status flags
  typedef struct packed {
    logic n;
    logic c;
    logic z;
    logic v;
  } sxa_flags_t;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sxa_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } sxa_apb_rsp_t;

endpackage : sxa_pkg

// *** hdl/sxa_barrel_shifter.sv ***
// barrel shifter with carry and overflow results
`timescale 1ns/1ps
`default_nettype none

module sxa_barrel_shifter #(
  parameter int WIDTH = 32,
  parameter int CNT_W = $clog2(WIDTH)
) (
  input  wire logic [WIDTH-1:0]  value,
  input  wire logic [CNT_W-1:0]  amount,
  input  wire sxa_pkg::sxa_shift_t kind,
  output logic      [WIDTH-1:0]  result,
  output logic                   carry,
  output logic                   overflow
);
  import sxa_pkg::*;

  // refuse widths the count field cannot address exactly
  if (WIDTH < 2 || (1 << CNT_W) != WIDTH) begin : g_bad_width
    $error("sxa_barrel_shifter: WIDTH must be a power of two");
  end

  logic [2*WIDTH-1:0] up;
  logic [2*WIDTH-1:0] down;

  // shift into a double-width word so the bits that leave stay visible
  always_comb begin
    up   = {{WIDTH{1'b0}}, value} << amount;
    down = (kind == sh_sra) ?
           $unsigned($signed({value, {WIDTH{1'b0}}}) >>> amount) :
           ({value, {WIDTH{1'b0}}} >> amount);
    result   = value;
    carry    = 1'b0;
    overflow = 1'b0;
    case (kind)
      sh_rotl: begin
        result = up[WIDTH-1:0] | up[2*WIDTH-1:WIDTH];
        carry  = (amount != '0) & result[0];
      end
      sh_sla: begin
        result   = up[WIDTH-1:0];
        carry    = (amount != '0) & up[WIDTH];
        overflow = ($signed(up[WIDTH-1:0]) >>> amount) != $signed(value);
      end
      sh_sll: begin
        result = up[WIDTH-1:0];
        carry  = (amount != '0) & up[WIDTH];
      end
      sh_sra: begin
        result = down[2*WIDTH-1:WIDTH];
        carry  = (amount != '0) & down[WIDTH-1];
      end
      sh_srl: begin
        result = down[2*WIDTH-1:WIDTH];
        carry  = (amount != '0) & down[WIDTH-1];
      end
      default: begin
        result = value;
      end
    endcase
  end

endmodule : sxa_barrel_shifter

`default_nettype wire

// *** hdl/sxa_xy_unit.sv ***
// half-wise xy add, subtract and compare
`timescale 1ns/1ps
`default_nettype none

module sxa_xy_unit #(
  parameter int HALF = 16
) (
  input  wire logic [2*HALF-1:0] dst,
  input  wire logic [2*HALF-1:0] src,
  input  wire sxa_pkg::sxa_xy_t  kind,
  output logic      [2*HALF-1:0] result,
  output logic      [1:0]        half_zero,
  output logic      [1:0]        half_neg
);
  import sxa_pkg::*;

  if (HALF < 2) begin : g_bad_half
    $error("sxa_xy_unit: HALF must be at least 2");
  end

  // index 0 is x in the low half, index 1 is y in the high half
  for (genvar h = 0; h < 2; h++) begin : g_half
    logic [HALF-1:0] a;
    logic [HALF-1:0] b;
    logic [HALF-1:0] r;
    assign a = dst[h*HALF +: HALF];
    assign b = src[h*HALF +: HALF];
    // each half wraps on its own; no carry crosses the boundary
    assign r = (kind == xy_sub) ? a - b : a + b;
    assign result[h*HALF +: HALF] = r;
    assign half_zero[h] = (r == '0);
    assign half_neg[h]  = r[HALF-1];
  end

endmodule : sxa_xy_unit

`default_nettype wire

// *** hdl/sxa_datapath.sv ***
// shift, xy and magnitude datapath slice behind an apb register slave
//
// Summary of operation
// - Condition code 1000 is true when carry is set, 1001 when it is clear.
// - Condition code 1100 is true when overflow is set.
// - The shift count comes from the 5-bit command constant or the low five source bits.
// - Register-count right shifts use the two's complement of the five count bits.
// - Rotate left feeds bits leaving the msb into the lsb; carry is the last bit out.
// - Arithmetic shift up fills zeros, carry is the last msb out, overflow on any sign change.
// - Logical shift up fills zeros, carry is the last msb out, no overflow check.
// - Arithmetic shift down replicates the sign; carry is the last lsb out.
// - Logical shift down fills zeros from bit 31; carry is the last lsb out.
// - An xy word holds x in the low 16 bits and y in the high 16 bits.
// - X and y halves are independent; no carry or borrow crosses between them.
// - Half copies move only x or only y of the source and keep the other half.
// - Xy add, subtract and compare work on each half separately.
// - Magnitude computes zero minus the operand and writes it back only if non-negative.
// - After magnitude the negative flag is the sign of zero minus the operand.
// - Magnitude keeps carry, sets zero for a zero operand, overflow for 80000000h.
`timescale 1ns/1ps
`default_nettype none

`include "sxa_cfg.svh"

module sxa_datapath #(
  parameter int WIDTH  = 32,
  parameter int ADDR_W = 8
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire sxa_pkg::sxa_apb_req_t apb_req,
  output var  sxa_pkg::sxa_apb_rsp_t apb_rsp
);
  import sxa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // the datapath, xy split and register map are laid out for one word size
  if (WIDTH != 32) begin : g_bad_width
    $error("sxa_datapath: WIDTH must be 32");
  end
  if (ADDR_W != 8) begin : g_bad_addr
    $error("sxa_datapath: ADDR_W must be 8");
  end

  localparam int HALF = WIDTH / 2;
  localparam int CNT_W = `SXA_CMD_K_W;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [WIDTH-1:0]     dst;
    logic [WIDTH-1:0]     src;
    sxa_flags_t           flags;
    logic [`SXA_CMD_W-1:0] cmd;
    logic                 cond_true;
    logic                 pready;
    logic [WIDTH-1:0]     prdata;
    logic                 pslverr;
  } sxa_state_t;

  sxa_state_t st;
  sxa_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // condition evaluation

  // jump condition from a code and the flags
  function automatic logic cond_eval(input logic [3:0] cc,
                                     input sxa_flags_t f);
    logic r;
    r = 1'b0;
    case (cc)
      `SXA_CC_UC: r = 1'b1;
      `SXA_CC_P:  r = ~f.n & ~f.z;
      `SXA_CC_LS: r = f.c | f.z;
      `SXA_CC_HI: r = ~f.c & ~f.z;
      `SXA_CC_LT: r = f.n ^ f.v;
      `SXA_CC_GE: r = ~(f.n ^ f.v);
      `SXA_CC_LE: r = (f.n ^ f.v) | f.z;
      `SXA_CC_GT: r = ~(f.n ^ f.v) & ~f.z;
      `SXA_CC_B:  r = f.c;
      `SXA_CC_NB: r = ~f.c;
      `SXA_CC_EQ: r = f.z;
      `SXA_CC_NE: r = ~f.z;
      `SXA_CC_V:  r = f.v;
      `SXA_CC_NV: r = ~f.v;
      `SXA_CC_N:  r = f.n;
      `SXA_CC_NN: r = ~f.n;
      default:    r = 1'b0;
    endcase
    return r;
  endfunction : cond_eval

  ////////////////////////////////////////////////////////////////////////////
  // command decode from the write data

  logic [ADDR_W-1:0]   addr;
  logic                setup_seen;
  logic                commit;
  logic [`SXA_CMD_W-1:0] wcmd;
  logic [3:0]          wop_raw;
  sxa_op_t             wop;
  logic                wop_bad;
  logic                reg_count;
  logic [CNT_W-1:0]    imm_count;
  logic [CNT_W-1:0]    src_count;
  logic [CNT_W-1:0]    shift_count;
  logic                is_down;

  assign addr       = apb_req.paddr;
  assign setup_seen = apb_req.psel & apb_req.penable & ~st.pready;
  assign commit     = apb_req.psel & apb_req.penable & st.pready;
  assign wcmd       = apb_req.pwdata[`SXA_CMD_W-1:0];
  assign wop_raw    = wcmd[`SXA_CMD_OP_LSB +: `SXA_CMD_OP_W];
  assign wop        = sxa_op_t'(wop_raw);
  assign wop_bad    = wop_raw > 4'(op_compare_halves);
  assign reg_count  = wcmd[`SXA_CMD_REGCNT];
  assign imm_count  = wcmd[`SXA_CMD_K_LSB +: `SXA_CMD_K_W];
  assign is_down    = (wop == op_arith_shift_down) |
                      (wop == op_logical_shift_down);

  // count from the register negates for the downward forms
  assign src_count   = is_down ? CNT_W'(-st.src[CNT_W-1:0]) :
                                 st.src[CNT_W-1:0];
  assign shift_count = reg_count ? src_count : imm_count;

  ////////////////////////////////////////////////////////////////////////////
  // functional units

  sxa_shift_t       sh_kind;
  logic [WIDTH-1:0] sh_result;
  logic             sh_carry;
  logic             sh_ovf;
  sxa_xy_t          xy_kind;
  logic [WIDTH-1:0] xy_result;
  logic [1:0]       xy_zero;
  logic [1:0]       xy_neg;

  // shifter mode from the operation
  always_comb begin
    case (wop)
      op_rotate_left:        sh_kind = sh_rotl;
      op_arith_shift_up:     sh_kind = sh_sla;
      op_logical_shift_up:   sh_kind = sh_sll;
      op_arith_shift_down:   sh_kind = sh_sra;
      op_logical_shift_down: sh_kind = sh_srl;
      default:               sh_kind = sh_sll;
    endcase
  end

  assign xy_kind = (wop == op_add_halves) ? xy_add : xy_sub;

  sxa_barrel_shifter #(
    .WIDTH (WIDTH),
    .CNT_W (CNT_W)
  ) u_shifter (
    .value    (st.dst),
    .amount   (shift_count),
    .kind     (sh_kind),
    .result   (sh_result),
    .carry    (sh_carry),
    .overflow (sh_ovf)
  );

  sxa_xy_unit #(
    .HALF (HALF)
  ) u_xy (
    .dst       (st.dst),
    .src       (st.src),
    .kind      (xy_kind),
    .result    (xy_result),
    .half_zero (xy_zero),
    .half_neg  (xy_neg)
  );

  // magnitude: zero minus the operand
  logic [WIDTH-1:0] mag_diff;
  assign mag_diff = WIDTH'(0) - st.dst;

  ////////////////////////////////////////////////////////////////////////////
  // read mux and address decode

  logic [WIDTH-1:0] rd_data;
  logic             addr_ok;
  logic             wr_err;

  // read data and decode of the mapped offsets
  always_comb begin
    rd_data = '0;
    addr_ok = 1'b1;
    case (addr)
      `SXA_OFF_DST:   rd_data = st.dst;
      `SXA_OFF_SRC:   rd_data = st.src;
      `SXA_OFF_FLAGS: rd_data = WIDTH'(st.flags);
      `SXA_OFF_CMD:   rd_data = WIDTH'(st.cmd);
      `SXA_OFF_COND:  rd_data = WIDTH'(st.cond_true);
      default:        addr_ok = 1'b0;
    endcase
  end

  // an undefined operation code is refused as a slave error
  assign wr_err = apb_req.pwrite & (addr == `SXA_OFF_CMD) & wop_bad;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    // one wait state, answer raised after the first access cycle
    next_st.pready = setup_seen;
    if (setup_seen) begin
      next_st.prdata  = apb_req.pwrite ? '0 : rd_data;
      next_st.pslverr = ~addr_ok | wr_err;
    end
    // register writes take effect only at the completing edge
    if (commit & apb_req.pwrite & addr_ok & ~wr_err) begin
      case (addr)
        `SXA_OFF_DST:   next_st.dst   = apb_req.pwdata;
        `SXA_OFF_SRC:   next_st.src   = apb_req.pwdata;
        `SXA_OFF_FLAGS: next_st.flags = sxa_flags_t'(apb_req.pwdata[3:0]);
        `SXA_OFF_CMD: begin
          next_st.cmd = wcmd;
          case (wop)
            op_rotate_left, op_logical_shift_up,
            op_logical_shift_down: begin
              next_st.dst     = sh_result;
              next_st.flags.c = sh_carry;
              next_st.flags.z = (sh_result == '0);
            end
            op_arith_shift_up: begin
              next_st.dst     = sh_result;
              next_st.flags.n = sh_result[WIDTH-1];
              next_st.flags.c = sh_carry;
              next_st.flags.z = (sh_result == '0);
              next_st.flags.v = sh_ovf;
            end
            op_arith_shift_down: begin
              next_st.dst     = sh_result;
              next_st.flags.n = sh_result[WIDTH-1];
              next_st.flags.c = sh_carry;
              next_st.flags.z = (sh_result == '0);
            end
            op_magnitude: begin
              if (!mag_diff[WIDTH-1]) begin
                next_st.dst = mag_diff;
              end
              next_st.flags.n = mag_diff[WIDTH-1];
              next_st.flags.z = (st.dst == '0);
              next_st.flags.v = (st.dst == `SXA_MOST_NEG);
            end
            op_copy_low_half: begin
              next_st.dst[HALF-1:0] = st.src[HALF-1:0];
            end
            op_copy_high_half: begin
              next_st.dst[WIDTH-1:HALF] = st.src[WIDTH-1:HALF];
            end
            op_add_halves, op_sub_halves, op_compare_halves: begin
              if (wop != op_compare_halves) begin
                next_st.dst = xy_result;
              end
              next_st.flags.n = xy_zero[0];
              next_st.flags.v = xy_neg[0];
              next_st.flags.c = xy_neg[1];
              next_st.flags.z = xy_zero[1];
            end
            default: begin
              next_st.dst = st.dst;
            end
          endcase
        end
        default: begin
          next_st.dst = st.dst;
        end
      endcase
    end
    // condition of the stored code against the flags as they will stand
    next_st.cond_true = cond_eval(next_st.cmd[`SXA_CMD_CC_LSB +:
                                              `SXA_CMD_CC_W],
                                  next_st.flags);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st.dst       <= `SXA_RST_DST;
      st.src       <= `SXA_RST_SRC;
      st.flags     <= sxa_flags_t'(`SXA_RST_FLAGS);
      st.cmd       <= `SXA_RST_CMD;
      st.cond_true <= 1'b1;
      st.pready    <= 1'b0;
      st.prdata    <= '0;
      st.pslverr   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // answer straight from the state flops
  assign apb_rsp.pready  = st.pready;
  assign apb_rsp.prdata  = st.prdata;
  assign apb_rsp.pslverr = st.pslverr;

endmodule : sxa_datapath

`default_nettype wire

// *** verification/sxa_datapath_chk.sv ***
// port-level checker for the shift/xy datapath apb slave
`timescale 1ns/1ps
`default_nettype none

module sxa_datapath_chk (
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire sxa_pkg::sxa_apb_req_t apb_req,
  input wire sxa_pkg::sxa_apb_rsp_t apb_rsp
);
  import sxa_pkg::*;

  logic acc;
  logic rdy;
  logic bad_op;
  logic unmapped;

  // access phase, answer and refusal conditions
  assign acc      = apb_req.psel && apb_req.penable;
  assign rdy      = apb_rsp.pready;
  assign bad_op   = apb_req.pwrite && apb_req.paddr == 8'h0C
                    && apb_req.pwdata[3:0] > 4'hB;
  assign unmapped = apb_req.paddr > 8'h10 || apb_req.paddr[1:0] != 2'b00;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  wait_state_a: assert property ($rose(acc) |-> !rdy ##1 rdy)
    else $error("ready not after one wait state");
  one_pulse_a: assert property (rdy |=> !rdy)
    else $error("ready longer than one cycle");
  ready_access_a: assert property (rdy |-> acc)
    else $error("ready outside access phase");
  write_zero_a: assert property (rdy && apb_req.pwrite |-> !apb_rsp.prdata)
    else $error("read data not zero on write");
  unmapped_err_a: assert property (rdy && unmapped |->
      apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped access not refused");
  bad_op_a: assert property (rdy && bad_op |-> apb_rsp.pslverr)
    else $error("illegal op not refused");
  mapped_ok_a: assert property (rdy && !unmapped && !bad_op |->
      !apb_rsp.pslverr)
    else $error("legal access refused");
  flags_width_a: assert property (rdy && !apb_req.pwrite
      && apb_req.paddr == 8'h08 |-> apb_rsp.prdata[31:4] == 28'h0)
    else $error("flag word upper bits set");
  cond_width_a: assert property (rdy && !apb_req.pwrite
      && apb_req.paddr == 8'h10 |-> apb_rsp.prdata[31:1] == 31'h0)
    else $error("condition word upper bits set");
  data_hold_a: assert property (!rdy |-> $stable(apb_rsp.prdata))
    else $error("read data moved without ready");
endmodule : sxa_datapath_chk

`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the shift/xy datapath
`timescale 1ns/1ps
`default_nettype none

`include "sxa_cfg.svh"

module tb_top;
  import sxa_pkg::*;

  logic         clock;
  logic         rst_n;
  sxa_apb_req_t req;
  sxa_apb_rsp_t rsp;
  int           n_errors;
  int           comparisons;
  logic [31:0]  m_dst;
  logic [31:0]  m_src;
  sxa_flags_t   m_fl;
  logic         m_cond;
  logic [31:0]  rd;
  logic         er;
  logic [3:0]   cc_tab [9] = '{4'h0, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD,
                               4'hE, 4'hF};
  logic [31:0]  mags [6] = '{32'h0, 32'h8000_0000, 32'h7FFF_FFFF,
                             32'hFFFF_FFFF, 32'hFFFA_0011, 32'h1};
  logic [31:0]  xys [6] = '{32'h0000_FFFF, 32'h0001_0001, 32'h0,
                            32'h0001_0001, 32'h8000_7FFF, 32'h8000_0001};
  logic [4:0]   cnts [3] = '{5'd0, 5'd1, 5'd31};

  sxa_datapath dut (
    .clock   (clock),
    .rst_n   (rst_n),
    .apb_req (req),
    .apb_rsp (rsp)
  );

  // free-running core clock
  always #10 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask : check

  // one apb transfer; waits for ready under a bound, idles one cycle after
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r,
                     output logic e);
    int i;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge clock);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (rsp.pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_errors++;
      final_report();
    end
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  // expected dst, flags and condition after one command
  function automatic void model(input logic [3:0] op, input logic rc,
                                input logic [4:0] k, input logic [3:0] cc);
    logic [4:0]  n;
    logic [31:0] r;
    logic [15:0] x;
    logic [15:0] y;
    n = rc ? m_src[4:0] : k;
    if (rc && (op == 4'd4 || op == 4'd5)) n = 5'd0 - n;
    r = m_dst;
    case (op)
      4'd1, 4'd2, 4'd3: begin
        r = m_dst << n;
        if (op == 4'd1 && n != 0) r = r | (m_dst >> (6'd32 - n));
        m_fl.c = (n != 0) ? m_dst[6'd32 - n] : 1'b0;
        if (op == 4'd2) begin
          m_fl.v = n != 0 && ($signed(r) >>> n) != $signed(m_dst);
          m_fl.n = r[31];
        end
      end
      4'd4, 4'd5: begin
        if (op == 4'd4) r = $signed(m_dst) >>> n;
        if (op == 4'd5) r = m_dst >> n;
        m_fl.c = (n != 0) ? m_dst[n - 5'd1] : 1'b0;
        if (op == 4'd4) m_fl.n = r[31];
      end
      4'd6: begin
        r = 32'h0 - m_dst;
        m_fl.n = r[31];
        m_fl.z = m_dst == 32'h0;
        m_fl.v = m_dst == 32'h8000_0000;
        if (!r[31]) m_dst = r;
      end
      4'd7: m_dst[15:0] = m_src[15:0];
      4'd8: m_dst[31:16] = m_src[31:16];
      4'd9, 4'd10, 4'd11: begin
        x = op == 4'd9 ? m_dst[15:0] + m_src[15:0] : m_dst[15:0] - m_src[15:0];
        y = op == 4'd9 ? m_dst[31:16] + m_src[31:16]
                       : m_dst[31:16] - m_src[31:16];
        m_fl = {x == 16'h0, y[15], y == 16'h0, x[15]};
        if (op != 4'd11) m_dst = {y, x};
      end
      default: ;
    endcase
    if (op >= 4'd1 && op <= 4'd5) begin
      m_fl.z = r == 32'h0;
      m_dst = r;
    end
    case (cc)
      4'h1: m_cond = !m_fl.n && !m_fl.z;
      4'h2: m_cond = m_fl.c || m_fl.z;
      4'h3: m_cond = !m_fl.c && !m_fl.z;
      4'h4: m_cond = m_fl.n ^ m_fl.v;
      4'h5: m_cond = !(m_fl.n ^ m_fl.v);
      4'h6: m_cond = (m_fl.n ^ m_fl.v) || m_fl.z;
      4'h7: m_cond = !(m_fl.n ^ m_fl.v) && !m_fl.z;
      4'h8: m_cond = m_fl.c;
      4'h9: m_cond = !m_fl.c;
      4'hA: m_cond = m_fl.z;
      4'hB: m_cond = !m_fl.z;
      4'hC: m_cond = m_fl.v;
      4'hD: m_cond = !m_fl.v;
      4'hE: m_cond = m_fl.n;
      4'hF: m_cond = !m_fl.n;
      default: m_cond = 1'b1;
    endcase
  endfunction : model

  // load operands, run one command, read back and compare
  task automatic run(input logic [31:0] d, input logic [31:0] s,
                     input logic [3:0] f, input logic [3:0] op, input logic rc,
                     input logic [4:0] k, input logic [3:0] cc);
    apb(1'b1, `SXA_OFF_DST, d, rd, er);
    apb(1'b1, `SXA_OFF_SRC, s, rd, er);
    apb(1'b1, `SXA_OFF_FLAGS, {28'h0, f}, rd, er);
    m_dst = d;
    m_src = s;
    m_fl = f;
    model(op, rc, k, cc);
    apb(1'b1, `SXA_OFF_CMD, {18'h0, cc, k, rc, op}, rd, er);
    check({31'h0, er}, 32'h0, "cmd err");
    apb(1'b0, `SXA_OFF_DST, 32'h0, rd, er);
    check(rd, m_dst, "dst");
    apb(1'b0, `SXA_OFF_FLAGS, 32'h0, rd, er);
    check(rd, {28'h0, m_fl}, "flags");
    apb(1'b0, `SXA_OFF_COND, 32'h0, rd, er);
    check(rd, {31'h0, m_cond}, "cond");
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    req = '0;
    n_errors = 0;
    comparisons = 0;
    rd = $urandom(32'h5361D74A);
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, `SXA_OFF_COND, 32'h0, rd, er);
    check(rd, 32'h1, "reset cond");
    // magnitude corners with carry preset
    foreach (mags[i]) run(mags[i], 32'h0, 4'h4, 4'd6, 1'b0, 5'd0, 4'hC);
    // every shift, immediate and register counts at the edges
    for (int op = 1; op <= 5; op++) begin
      foreach (cnts[j]) begin
        run(32'hA000_0003, 32'h0, 4'h0, 4'(op), 1'b0, cnts[j], 4'h8);
        run(32'h4000_0001, {27'h0, cnts[j]}, 4'hF, 4'(op), 1'b1, 5'd0, 4'h9);
      end
    end
    // half copies and half arithmetic across the x/y boundary
    for (int op = 7; op <= 11; op++) begin
      for (int j = 0; j < 6; j += 2) begin
        run(xys[j], xys[j + 1], 4'h0, 4'(op), 1'b0, 5'd0, cc_tab[op - 3]);
      end
    end
    repeat (150) begin
      run($urandom, $urandom, 4'($urandom), 4'($urandom_range(11)),
          1'($urandom), 5'($urandom), 4'($urandom));
    end
    // refusals: illegal op, unmapped word; a write to the condition word is accepted and ignored
    apb(1'b1, `SXA_OFF_CMD, 32'h0000_002C, rd, er);
    check({31'h0, er}, 32'h1, "bad op err");
    apb(1'b0, `SXA_OFF_DST, 32'h0, rd, er);
    check(rd, m_dst, "bad op dst");
    apb(1'b0, 8'h14, 32'h0, rd, er);
    check(rd, 32'h0, "unmapped data");
    check({31'h0, er}, 32'h1, "unmapped err");
    apb(1'b1, `SXA_OFF_COND, 32'h0, rd, er);
    check({31'h0, er}, 32'h0, "cond write err");
    apb(1'b0, `SXA_OFF_COND, 32'h0, rd, er);
    check(rd, {31'h0, m_cond}, "cond write");
    final_report();
  end
endmodule : tb_top

bind sxa_datapath sxa_datapath_chk chk (
  .clock   (clock),
  .rst_n   (rst_n),
  .apb_req (apb_req),
  .apb_rsp (apb_rsp)
);

`default_nettype wire
